// ### hdl/dtp_position_latch.sv
`timescale 1ns/100ps
// Behaviour
// - Two independent probes with own storage.
// - Enabled probe trigger stores current motor position.
// - Source byte: 0 feedback, 1 command.
// - Trigger byte: 0 zero signal, 1 timing.
// - Probe one external A, probe two B.
// - Both internal outputs usable by both probes.
// - Timing output pulses every 7.2 degrees.
// - Signed rising and falling captures per probe.
// - Config word 16-bit read-write, cyclic, resets zero.
// - Config bytes: enable, mode, source, edges.
// - Status bytes: enabled, rising, falling; rest zero.
// - Zero signal feedback, timing command position.
// ==========================================================================
// Top level: object access, configuration store, status and captures of
// the two touch probes of one axis.
// ==========================================================================
module dtp_position_latch #(
  parameter int AXIS_NUM      = 1,     // Axis served by this instance.
  parameter int STEPS_PER_REV = 10000  // Steps per output shaft turn.
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire dtp_pkg::dtp_obj_req_t obj_req,
  input  wire logic                  cyc_cfg_valid,
  input  wire logic [15:0]           cyc_cfg_word,
  input  wire logic                  external_latch_in_a,
  input  wire logic                  external_latch_in_b,
  input  wire logic                  zero_signal_output,
  input  wire logic [31:0]           fb_pos,
  input  wire logic [31:0]           cmd_pos,
  output dtp_pkg::dtp_obj_rsp_t      obj_rsp,
  output logic [15:0]                cyc_status,
  output logic [3:0][31:0]           cyc_positions,
  output logic                       rotation_timing_output
);
  // ========================================================================
  // Elaboration checks.
  // ========================================================================

  // Only four axes exist on the driver; anything else has no sub-index.
  if (AXIS_NUM < 1 || AXIS_NUM > 4)
    $error("dtp_position_latch: axis number must be 1 to 4");

  // Sub-index that addresses this axis' manufacturer objects.
  localparam logic [7:0] AXIS_SUB = 8'(AXIS_NUM);

  // ========================================================================
  // State.
  // ========================================================================

  // All registers of this module in one record.
  typedef struct packed {
    logic [15:0]           cfg_word;  // Probe configuration word.
    logic [1:0][7:0]       src_sel;   // Capture source per probe.
    logic [1:0][7:0]       trg_sel;   // Internal trigger per probe.
    dtp_pkg::dtp_obj_rsp_t rsp;       // Object answer.
    logic [15:0]           status;    // Cyclic copy of the status.
    logic [3:0][31:0]      pos;       // Cyclic copy of the captures.
  } dtp_main_st_t;

  dtp_main_st_t          st_reg;   // Registered state.
  dtp_main_st_t          st_next;  // Next state.
  dtp_pkg::dtp_dec_t     dec;      // Decoded object address.
  logic [15:0]           status_w; // Live status word.
  logic [3:0][31:0]      pos_w;    // Live captured positions.
  logic                  tim_w;    // Rotation timing level.
  logic [1:0]            ext_w;    // External latch inputs per probe.

  // ========================================================================
  // Address decode.
  // ========================================================================

  // Maps index and sub-index onto a target. Manufacturer objects answer
  // only to this axis' sub-index; profile objects only to sub-index 0.
  function automatic dtp_pkg::dtp_dec_t obj_decode(
    input logic [15:0] idx,
    input logic [7:0]  sub
  );
    dtp_pkg::dtp_dec_t d;
    logic [15:0]       off;
    d.kind = dtp_pkg::OBJ_NONE;
    d.sel = 2'b00;
    off = idx - dtp_pkg::IDX_P1R;
    if (sub == AXIS_SUB) begin
      if (idx == dtp_pkg::IDX_SRC1 || idx == dtp_pkg::IDX_SRC2) begin
        d.kind = dtp_pkg::OBJ_SRC;
        d.sel = {1'b0, idx[0]};
      end else if (idx == dtp_pkg::IDX_TRG1 ||
                   idx == dtp_pkg::IDX_TRG2) begin
        d.kind = dtp_pkg::OBJ_TRG;
        d.sel = {1'b0, idx[0]};
      end
    end
    if (sub == dtp_pkg::SUB_STD) begin
      if (idx == dtp_pkg::IDX_CFG) begin
        d.kind = dtp_pkg::OBJ_CFG;
      end else if (idx == dtp_pkg::IDX_STAT) begin
        d.kind = dtp_pkg::OBJ_STAT;
      end else if (idx >= dtp_pkg::IDX_P1R &&
                   idx <= dtp_pkg::IDX_P2F) begin
        d.kind = dtp_pkg::OBJ_POS;
        d.sel = off[1:0];
      end
    end
    return d;
  endfunction : obj_decode

  assign dec = obj_decode(obj_req.index, obj_req.sub);

  // ========================================================================
  // Probe channels.
  // ========================================================================

  // Each probe has its own external pin.
  assign ext_w = {external_latch_in_b, external_latch_in_a};

  // Timing output shared by both probes.
  dtp_timing_gen #(
    .STEPS_PER_REV (STEPS_PER_REV)
  ) u_timing (
    .clk     (clk),
    .rst     (rst),
    .cmd_pos (cmd_pos),
    .tim_out (tim_w)
  );

  // Two identical channels; the byte of the config word picks the lane.
  for (genvar g = 0; g < 2; g++) begin : g_probe
    dtp_pkg::dtp_probe_cfg_t pcfg; // Channel configuration.
    dtp_pkg::dtp_probe_st_t  pst;  // Channel state.
    logic [7:0]              cb;   // This probe's config byte.

    assign cb = st_reg.cfg_word[g*dtp_pkg::PROBE_W +: dtp_pkg::PROBE_W];
    assign pcfg.enable = cb[dtp_pkg::CFG_EN_BIT];
    assign pcfg.continuous = cb[dtp_pkg::CFG_CONT_BIT];
    assign pcfg.internal = cb[dtp_pkg::CFG_INT_BIT];
    assign pcfg.rise_en = cb[dtp_pkg::CFG_RISE_BIT];
    assign pcfg.fall_en = cb[dtp_pkg::CFG_FALL_BIT];
    assign pcfg.src_sel = st_reg.src_sel[g];
    assign pcfg.trg_sel = st_reg.trg_sel[g];

    dtp_probe_channel u_chan (
      .clk      (clk),
      .rst      (rst),
      .cfg      (pcfg),
      .ext_trig (ext_w[g]),
      .zero_sig (zero_signal_output),
      .tim_sig  (tim_w),
      .fb_pos   (fb_pos),
      .cmd_pos  (cmd_pos),
      .st       (pst)
    );

    // Status byte: reserved bits read zero.
    assign status_w[g*dtp_pkg::PROBE_W +: dtp_pkg::PROBE_W] =
      {5'h00, pst.fall_flag, pst.rise_flag, pst.enabled};
    assign pos_w[2*g] = pst.rise_pos;
    assign pos_w[2*g+1] = pst.fall_pos;
  end

  // ========================================================================
  // Object access and configuration.
  // ========================================================================

  // Every request is answered in the next cycle. A cyclic config update
  // and an acyclic write in the same cycle resolve to the acyclic one,
  // since it is the more deliberate of the two.
  always_comb begin
    st_next = st_reg;
    st_next.rsp.ack = 1'b0;
    st_next.rsp.err = 1'b0;
    st_next.rsp.rdata = 32'h0000_0000;
    st_next.status = status_w;
    st_next.pos = pos_w;
    if (cyc_cfg_valid) begin
      st_next.cfg_word = cyc_cfg_word;
    end
    if (obj_req.req) begin
      st_next.rsp.ack = 1'b1;
      unique case (dec.kind)
        dtp_pkg::OBJ_CFG: begin
          if (obj_req.wr) begin
            // Any 16-bit pattern is accepted.
            st_next.cfg_word = obj_req.wdata[15:0];
          end else begin
            st_next.rsp.rdata = {16'h0000, st_reg.cfg_word};
          end
        end
        dtp_pkg::OBJ_SRC: begin
          if (!obj_req.wr) begin
            st_next.rsp.rdata = {24'h00_0000, st_reg.src_sel[dec.sel[0]]};
          end else if (obj_req.wdata > {24'h00_0000, dtp_pkg::SEL_MAX}) begin
            // Out of range values leave the setting alone.
            st_next.rsp.err = 1'b1;
          end else begin
            st_next.src_sel[dec.sel[0]] = obj_req.wdata[7:0];
          end
        end
        dtp_pkg::OBJ_TRG: begin
          if (!obj_req.wr) begin
            st_next.rsp.rdata = {24'h00_0000, st_reg.trg_sel[dec.sel[0]]};
          end else if (obj_req.wdata > {24'h00_0000, dtp_pkg::SEL_MAX}) begin
            st_next.rsp.err = 1'b1;
          end else begin
            st_next.trg_sel[dec.sel[0]] = obj_req.wdata[7:0];
          end
        end
        dtp_pkg::OBJ_STAT: begin
          // Read only: a write is refused.
          st_next.rsp.err = obj_req.wr;
          if (!obj_req.wr) begin
            st_next.rsp.rdata = {16'h0000, status_w};
          end
        end
        dtp_pkg::OBJ_POS: begin
          st_next.rsp.err = obj_req.wr;
          if (!obj_req.wr) begin
            st_next.rsp.rdata = pos_w[dec.sel];
          end
        end
        default: begin
          // Unknown index or wrong sub-index.
          st_next.rsp.err = 1'b1;
        end
      endcase
    end
  end

  // Single state register; reset values for all settings.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.cfg_word <= dtp_pkg::CFG_RST;
      st_reg.src_sel <= {2{dtp_pkg::SEL_RST}};
      st_reg.trg_sel <= {2{dtp_pkg::SEL_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Outputs, all taken from flip-flops.
  // ========================================================================
  assign obj_rsp = st_reg.rsp;
  assign cyc_status = st_reg.status;
  assign cyc_positions = st_reg.pos;
  assign rotation_timing_output = tim_w;

  // ========================================================================
  // Assertions.
  // ========================================================================
  a_obj_answer: assert property (@(posedge clk) disable iff (rst)
    obj_req.req |=> obj_rsp.ack ##1 !obj_rsp.ack || $past(obj_req.req))
    else $error("object request not answered in one cycle");
  a_ro_refuse: assert property (@(posedge clk) disable iff (rst)
    obj_req.req && obj_req.wr && obj_req.sub == dtp_pkg::SUB_STD
    && obj_req.index >= dtp_pkg::IDX_STAT
    && obj_req.index <= dtp_pkg::IDX_P2F |=> obj_rsp.err)
    else $error("write to read-only object accepted");
  a_sub_axis: assert property (@(posedge clk) disable iff (rst)
    obj_req.req && obj_req.index == dtp_pkg::IDX_SRC1
    && obj_req.sub != AXIS_SUB |=> obj_rsp.err)
    else $error("foreign axis sub-index accepted");
  a_cfg_write: assert property (@(posedge clk) disable iff (rst)
    obj_req.req && obj_req.wr && dec.kind == dtp_pkg::OBJ_CFG
    |=> st_reg.cfg_word == $past(obj_req.wdata[15:0]) && !obj_rsp.err)
    else $error("configuration write lost");
  a_status_zero: assert property (@(posedge clk) disable iff (rst)
    cyc_status[7:3] == 5'h00 && cyc_status[15:11] == 5'h00)
    else $error("reserved status bits set");
  a_status_enable: assert property (@(posedge clk) disable iff (rst)
    ##1 1'b1 |-> status_w[8] == $past(st_reg.cfg_word[8]))
    else $error("probe two enable not reported");
  c_cfg_write: cover property (@(posedge clk) disable iff (rst)
    obj_req.req && obj_req.wr && dec.kind == dtp_pkg::OBJ_CFG);
  c_both_latched: cover property (@(posedge clk) disable iff (rst)
    status_w[1] && status_w[9]);
  c_timing_edge: cover property (@(posedge clk) disable iff (rst)
    $rose(tim_w));

endmodule : dtp_position_latch

// ### common/dtp_pkg.sv
// ==========================================================================
// Shared constants and carriers for the dual touch probe position latch.
// ==========================================================================
package dtp_pkg;

  // ========================================================================
  // Object indices and sub-indices.
  // ========================================================================
  localparam logic [15:0] IDX_SRC1 = 16'h44b0; // Probe 1 capture source.
  localparam logic [15:0] IDX_SRC2 = 16'h44b1; // Probe 2 capture source.
  localparam logic [15:0] IDX_TRG1 = 16'h44b2; // Probe 1 internal trigger.
  localparam logic [15:0] IDX_TRG2 = 16'h44b3; // Probe 2 internal trigger.
  localparam logic [15:0] IDX_CFG  = 16'h60b8; // Configuration word.
  localparam logic [15:0] IDX_STAT = 16'h60b9; // Status word.
  localparam logic [15:0] IDX_P1R  = 16'h60ba; // Probe 1 rising capture.
  localparam logic [15:0] IDX_P1F  = 16'h60bb; // Probe 1 falling capture.
  localparam logic [15:0] IDX_P2R  = 16'h60bc; // Probe 2 rising capture.
  localparam logic [15:0] IDX_P2F  = 16'h60bd; // Probe 2 falling capture.
  localparam logic [7:0]  SUB_STD  = 8'h00;    // Sub-index of profile objects.

  // ========================================================================
  // Field positions, reset values and ranges.
  // ========================================================================
  localparam int          PROBE_W     = 8;  // Bits per probe in cfg/status.
  localparam int          CFG_EN_BIT  = 0;  // Probe enable.
  localparam int          CFG_CONT_BIT = 1; // Continuous capture.
  localparam int          CFG_INT_BIT = 2;  // Internal output as trigger.
  localparam int          CFG_RISE_BIT = 4; // Rising-edge capture enable.
  localparam int          CFG_FALL_BIT = 5; // Falling-edge capture enable.
  localparam logic [15:0] CFG_RST     = 16'h0000;
  localparam logic [7:0]  SEL_RST     = 8'h00;
  localparam logic [7:0]  SEL_MAX     = 8'h01; // Largest legal selector.

  // ========================================================================
  // Rotation timing: one pulse per 7.2 degrees, in milli-degrees.
  // ========================================================================
  localparam int TIM_STEP_MDEG = 7200;
  localparam int REV_MDEG      = 360000;

  // Object targets found by the address decoder.
  typedef enum logic [2:0] {
    OBJ_NONE = 3'h0,
    OBJ_SRC  = 3'h1,
    OBJ_TRG  = 3'h2,
    OBJ_CFG  = 3'h3,
    OBJ_STAT = 3'h4,
    OBJ_POS  = 3'h5
  } dtp_obj_t;

  // Decoded object: kind and probe or position number.
  typedef struct packed {
    dtp_obj_t   kind;
    logic [1:0] sel;
  } dtp_dec_t;

  // Acyclic object request from the fieldbus side.
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } dtp_obj_req_t;

  // Answer to an object request.
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dtp_obj_rsp_t;

  // Per-probe configuration handed to a channel.
  typedef struct packed {
    logic       enable;
    logic       continuous;
    logic       internal;
    logic       rise_en;
    logic       fall_en;
    logic [7:0] src_sel;
    logic [7:0] trg_sel;
  } dtp_probe_cfg_t;

  // Per-probe state, also the channel's output.
  typedef struct packed {
    logic        trig_prev;
    logic        enabled;
    logic        rise_flag;
    logic        fall_flag;
    logic [31:0] rise_pos;
    logic [31:0] fall_pos;
  } dtp_probe_st_t;

  // Rotation timing generator state.
  typedef struct packed {
    logic        primed;
    logic [31:0] prev_pos;
    logic [31:0] phase;
    logic        tim;
  } dtp_tim_st_t;

endpackage : dtp_pkg

// ### hdl/dtp_timing_gen.sv
`timescale 1ns/100ps
// ==========================================================================
// Rotation timing output: a square wave with one rising edge per 7.2
// degrees of command motion, derived by tracking the position phase.
// ==========================================================================
module dtp_timing_gen #(
  parameter int STEPS_PER_REV = 10000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] cmd_pos,
  output logic             tim_out
);
  // Steps between two timing pulses.
  localparam int PERIOD =
    (STEPS_PER_REV * dtp_pkg::TIM_STEP_MDEG) / dtp_pkg::REV_MDEG;

  // The period must be whole and long enough for a high and a low half.
  if (PERIOD < 2 ||
      (STEPS_PER_REV * dtp_pkg::TIM_STEP_MDEG) % dtp_pkg::REV_MDEG != 0)
    $error("dtp_timing_gen: steps per revolution give no whole period");

  dtp_pkg::dtp_tim_st_t st_reg;  // Registered state.
  dtp_pkg::dtp_tim_st_t st_next; // Next state.
  logic signed [33:0]   ph_sum;  // Phase plus motion, unwrapped.

  // Phase follows the motion. The remainder folds any jump, such as a
  // position preset, back into one period; pulses that a jump skips are
  // lost, a limit that users of the timing trigger must accept.
  always_comb begin
    st_next = st_reg;
    ph_sum = $signed({2'b00, st_reg.phase})
           + $signed({{2{cmd_pos[31]}}, cmd_pos})
           - $signed({{2{st_reg.prev_pos[31]}}, st_reg.prev_pos});
    st_next.prev_pos = cmd_pos;
    st_next.primed = 1'b1;
    if (!st_reg.primed) begin
      // First cycle after reset: take the position, move no phase.
      ph_sum = '0;
    end
    ph_sum = ph_sum % 34'(PERIOD);
    if (ph_sum < 0) begin
      // The remainder keeps the sign of phase plus motion; bring it back up.
      ph_sum = ph_sum + 34'(PERIOD);
    end
    st_next.phase = ph_sum[31:0];
    st_next.tim = (ph_sum < 34'(PERIOD / 2));
  end

  // Single state register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tim_out = st_reg.tim;

  // Phase always stays within one period.
  a_phase_range: assert property (@(posedge clk) disable iff (rst)
    st_reg.phase < 32'(PERIOD))
    else $error("timing phase left its period");

endmodule : dtp_timing_gen

// ### hdl/dtp_probe_channel.sv
`timescale 1ns/100ps
// ==========================================================================
// One touch probe: trigger choice, edge detection and position capture.
// ==========================================================================
module dtp_probe_channel (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire dtp_pkg::dtp_probe_cfg_t cfg,
  input  wire logic                   ext_trig,
  input  wire logic                   zero_sig,
  input  wire logic                   tim_sig,
  input  wire logic [31:0]            fb_pos,
  input  wire logic [31:0]            cmd_pos,
  output dtp_pkg::dtp_probe_st_t      st
);
  dtp_pkg::dtp_probe_st_t st_reg;  // Registered state.
  dtp_pkg::dtp_probe_st_t st_next; // Next state.
  logic                   trig;    // Selected trigger level.
  logic [31:0]            pos;     // Position to capture now.
  logic                   rise;    // Qualified rising capture.
  logic                   fall;    // Qualified falling capture.

  // Trigger and position selection.
  always_comb begin
    if (cfg.internal) begin
      // Both internal outputs are offered; the zero signal pairs with
      // feedback, the timing output with the command position.
      trig = (cfg.trg_sel != 8'h00) ? tim_sig : zero_sig;
      pos = (cfg.trg_sel != 8'h00) ? cmd_pos : fb_pos;
    end else begin
      trig = ext_trig;
      pos = (cfg.src_sel != 8'h00) ? cmd_pos : fb_pos;
    end
  end

  // Edge qualification; single shot locks a polarity once captured.
  assign rise = st_reg.enabled && cfg.enable && cfg.rise_en
              && trig && !st_reg.trig_prev
              && (cfg.continuous || !st_reg.rise_flag);
  assign fall = st_reg.enabled && cfg.enable && cfg.fall_en
              && !trig && st_reg.trig_prev
              && (cfg.continuous || !st_reg.fall_flag);

  // Next state: disable wipes status, captures keep their last value.
  always_comb begin
    st_next = st_reg;
    st_next.trig_prev = trig;
    st_next.enabled = cfg.enable;
    if (!cfg.enable) begin
      st_next.rise_flag = 1'b0;
      st_next.fall_flag = 1'b0;
    end
    if (rise) begin
      st_next.rise_flag = 1'b1;
      st_next.rise_pos = pos;
    end
    if (fall) begin
      st_next.fall_flag = 1'b1;
      st_next.fall_pos = pos;
    end
  end

  // Single state register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign st = st_reg;

  a_rise_capture: assert property (@(posedge clk) disable iff (rst)
    rise |=> st_reg.rise_flag && st_reg.rise_pos == $past(pos))
    else $error("rising edge did not capture");
  a_fall_capture: assert property (@(posedge clk) disable iff (rst)
    fall |=> st_reg.fall_flag && st_reg.fall_pos == $past(pos))
    else $error("falling edge did not capture");
  a_single_hold: assert property (@(posedge clk) disable iff (rst)
    st_reg.rise_flag && !cfg.continuous
      ##1 (cfg.enable && !cfg.continuous) [*2]
      |-> $stable(st_reg.rise_pos))
    else $error("single shot capture was overwritten");
  a_disable_clear: assert property (@(posedge clk) disable iff (rst)
    !cfg.enable |=> !st_reg.enabled && !st_reg.rise_flag
                    && !st_reg.fall_flag)
    else $error("disable did not clear status");
  c_cont_recapture: cover property (@(posedge clk) disable iff (rst)
    rise && st_reg.rise_flag);
  c_fall_seen: cover property (@(posedge clk) disable iff (rst) fall);

endmodule : dtp_probe_channel

// ### tb/dtp_master_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Controller model: one object access at a time over the request port.
// ==========================================================================
module dtp_master_model #(
  parameter int AXIS = 1 // Axis number placed in vendor sub-indices.
) (
  input  wire logic                  clk,
  output dtp_pkg::dtp_obj_req_t      obj_req,
  input  wire dtp_pkg::dtp_obj_rsp_t obj_rsp
);
  logic bad_sub = 1'b0; // A test sets this to aim at a foreign axis.
  initial obj_req = '0;
  // Called after an edge; gives up after eight edges without an answer.
  task automatic obj(input logic wr, input logic [15:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    obj_req <= '{1'b1, wr, idx, (idx[15:8] == 8'h44) ?
      8'(AXIS + int'(bad_sub)) : 8'h00, wd};
    @(posedge clk);
    // Released fields show garbage, not the last request.
    obj_req <= '{1'b0, ~wr, ~idx, 8'hff, ~wd};
    do begin
      @(posedge clk);
      n++;
    end while (obj_rsp.ack !== 1'b1 && n < 8);
    rd = obj_rsp.rdata;
    er = obj_rsp.err | (n >= 8);
  endtask : obj
endmodule : dtp_master_model

// ### tb/dual_touch_probe_position_latch_tb.sv
`timescale 1ns/100ps
module dual_touch_probe_position_latch_tb;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, ea = 1'b0, eb = 1'b0;
  logic zs = 1'b0, tim, tim_q, er, count_on = 1'b0;
  logic [15:0] cw = 16'h0000, st;
  logic [31:0] fb = 32'h0, cmd = 32'h0, rd;
  logic [3:0][31:0] pos;
  dtp_pkg::dtp_obj_req_t req;
  dtp_pkg::dtp_obj_rsp_t rsp;
  int err_count = 0, checks_done = 0, cycles = 0, rises = 0;
  always #4 clk = ~clk;
  dtp_master_model #(.AXIS(2)) i_master (.clk(clk), .obj_req(req),
    .obj_rsp(rsp));
  dtp_position_latch #(.AXIS_NUM(2), .STEPS_PER_REV(200)) i_dut (
    .clk(clk), .rst(rst), .obj_req(req), .cyc_cfg_valid(cv),
    .cyc_cfg_word(cw), .external_latch_in_a(ea), .external_latch_in_b(eb),
    .zero_signal_output(zs), .fb_pos(fb), .cmd_pos(cmd), .obj_rsp(rsp),
    .cyc_status(st), .cyc_positions(pos), .rotation_timing_output(tim));
  // Rising edges of the timing output, counted while a test asks.
  always @(posedge clk) begin
    tim_q <= tim;
    if (count_on && tim === 1'b1 && tim_q === 1'b0) rises++;
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // One object access, judging only whether it was refused.
  task automatic rw(input logic w, input logic [15:0] i,
    input logic [31:0] wd, input logic e);
    i_master.obj(w, i, wd, rd, er);
    check("refusal", 32'(er), 32'(e));
  endtask : rw
  // Cyclic configuration update, then time for status to settle.
  task automatic cfg(input logic [15:0] w);
    cw <= w;
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    tick(4);
  endtask : cfg
  task automatic t_regs;
    rw(0, dtp_pkg::IDX_SRC1, 0, 0);
    check("src1", rd, 0);
    rw(0, dtp_pkg::IDX_TRG2, 0, 0);
    check("trg2", rd, 0);
    rw(1, dtp_pkg::IDX_CFG, 32'hffff, 0);
    rw(0, dtp_pkg::IDX_CFG, 0, 0);
    check("cfg", rd, 32'hffff);
    rw(1, dtp_pkg::IDX_CFG, 0, 0);
    rw(1, dtp_pkg::IDX_TRG1, 2, 1);
    rw(1, dtp_pkg::IDX_STAT, 0, 1);
    rw(0, 16'h1234, 0, 1);
    i_master.bad_sub = 1'b1;
    rw(0, dtp_pkg::IDX_SRC1, 0, 1);
    i_master.bad_sub = 1'b0;
  endtask : t_regs
  task automatic t_timing;
    count_on = 1'b1;
    repeat (40) begin
      cmd <= cmd + 1;
      @(posedge clk);
    end
    tick(4);
    count_on = 1'b0;
    check("timing rises", 32'(rises), 10);
  endtask : t_timing
  // Probe 1 single shot on both edges, probe 2 continuous on rises.
  task automatic t_ext;
    rw(1, dtp_pkg::IDX_SRC2, 1, 0);
    fb <= 32'hffff_ff00;
    cmd <= 32'h500;
    cfg(16'h1331);
    check("status", 32'(st), 32'h0101);
    ea <= 1'b1;
    eb <= 1'b1;
    tick(4);
    check("p1 rise", pos[0], 32'hffff_ff00);
    check("p2 rise", pos[2], 32'h500);
    fb <= 32'h7;
    cmd <= 32'h9;
    ea <= 1'b0;
    eb <= 1'b0;
    tick(4);
    check("p1 fall", pos[1], 32'h7);
    check("p2 no fall", pos[3], 32'h0);
    check("status", 32'(st), 32'h0307);
    ea <= 1'b1;
    eb <= 1'b1;
    tick(4);
    check("p1 once", pos[0], 32'hffff_ff00);
    check("p2 again", pos[2], 32'h9);
    cfg(16'h1300);
    check("disable", 32'(st), 32'h0300);
  endtask : t_ext
  // Zero signal must capture feedback even with command selected.
  // Both probes are first disabled, so no single-shot lock survives.
  task automatic t_zero;
    rw(1, dtp_pkg::IDX_SRC1, 1, 0);
    fb <= 32'h1234;
    cfg(16'h0000);
    cfg(16'h1515);
    zs <= 1'b1;
    tick(4);
    check("zero p1", pos[0], 32'h1234);
    check("zero p2", pos[2], 32'h1234);
    rw(0, dtp_pkg::IDX_P1R, 0, 0);
    check("p1 read", rd, 32'h1234);
  endtask : t_zero
  // Timing output as trigger must capture the command position even
  // with feedback selected. Phase is 1 of 4 at command 9, so the
  // timing output rises as 12 is taken and probe 2 latches 13.
  task automatic t_tim;
    rw(1, dtp_pkg::IDX_SRC2, 0, 0);
    rw(1, dtp_pkg::IDX_TRG2, 1, 0);
    cfg(16'h0000);
    cfg(16'h1500);
    repeat (4) begin
      cmd <= cmd + 1;
      @(posedge clk);
    end
    tick(3);
    check("tim p2", pos[2], 32'hd);
    check("status", 32'(st), 32'h0300);
  endtask : t_tim
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    tick(3);
    rst <= 1'b0;
    tick(1);
    t_regs();
    $display("registers test done");
    t_timing();
    $display("timing test done");
    t_ext();
    $display("external test done");
    t_zero();
    $display("zero signal test done");
    t_tim();
    $display("timing trigger test done");
    conclude();
  end
endmodule : dual_touch_probe_position_latch_tb
